// File: rtl/ore_exec.sv
// Function
// - Immediate OR: work register ORed with literal; zero flag updated.
// - OR into memory: byte gets byte OR work register; zero flag updated.
// - Subroutine exit pops return address, fetches from it; flags kept.
// - Literal exit pops address, literal into work register; flags kept.
// - Interrupt exit pops address and sets global irq enable; flags kept.
// - Global interrupt enable is bit 0 of the interrupt control register.
// - Pending interrupt at interrupt exit runs before the return address.
// - Circular up shift of a memory byte, bit 7 into bit 0; flags kept.
`timescale 1ns/10ps
`include "ore_map.svh"
module ore_exec (
  // Clock and reset.
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // Decoded instruction.
  input  wire logic                 op_valid,
  input  wire ore_pkg::ore_op_e     op_code,
  input  wire logic [7:0]           op_literal,
  // Data memory read side for the addressed byte.
  input  wire logic [7:0]           mem_rdata,
  // Return-address stack.
  input  wire logic [10:0]          stack_top,
  // Interrupt request from the controller.
  input  wire logic                 irq_pending,
  // Data memory write side.
  output logic                      mem_we,
  output logic [7:0]                mem_wdata,
  // Stack pop and fetch redirect.
  output logic                      stack_pop,
  output logic                      pc_load,
  output logic [10:0]               pc_out,
  output logic                      irq_enter,
  // Core state.
  output logic [7:0]                work_reg,
  output logic                      zero_flag,
  output logic [7:0]                irq_control_reg,
  output logic                      global_irq_enable
);
  ore_pkg::ore_state_s st_q;
  ore_pkg::ore_state_s st_d;

  logic                is_or_imm;
  logic                is_or_mem;
  logic                is_sub_exit;
  logic                is_sub_exit_lit;
  logic                is_irq_exit;
  logic                is_shift_up;
  logic                is_any_exit;

  logic [7:0]          or_imm_res;
  logic [7:0]          or_mem_res;
  logic [7:0]          shift_res;
  logic                or_imm_zero;
  logic                or_mem_zero;
  logic                irq_divert;

  // Unknown or idle codes raise no flag at all, so they leave every
  // register except irq_take, which clears, and every strobe untouched.
  always_comb begin
    is_or_imm       = 1'h0;
    is_or_mem       = 1'h0;
    is_sub_exit     = 1'h0;
    is_sub_exit_lit = 1'h0;
    is_irq_exit     = 1'h0;
    is_shift_up     = 1'h0;
    if (op_valid) begin
      case (op_code)
        ore_pkg::ORE_OP_OR_IMM: begin
          is_or_imm = 1'h1;
        end
        ore_pkg::ORE_OP_OR_INTO_MEMORY: begin
          is_or_mem = 1'h1;
        end
        ore_pkg::ORE_OP_SUBROUTINE_EXIT: begin
          is_sub_exit = 1'h1;
        end
        ore_pkg::ORE_OP_SUBROUTINE_EXIT_WITH_LITERAL: begin
          is_sub_exit_lit = 1'h1;
        end
        ore_pkg::ORE_OP_IRQ_EXIT: begin
          is_irq_exit = 1'h1;
        end
        ore_pkg::ORE_OP_SHIFT_CIRCULAR_UP: begin
          is_shift_up = 1'h1;
        end
        default: begin
          is_shift_up = 1'h0;
        end
      endcase
    end
  end

  assign is_any_exit = is_sub_exit | is_sub_exit_lit | is_irq_exit;
  assign irq_divert  = is_irq_exit & irq_pending;

  ore_or_unit #(
    .WIDTH  (`ORE_BYTE_W)
  ) u_or_imm (
    .lhs    (st_q.work_reg),
    .rhs    (op_literal),
    .result (or_imm_res)
  );

  ore_or_unit #(
    .WIDTH  (`ORE_BYTE_W)
  ) u_or_mem (
    .lhs    (mem_rdata),
    .rhs    (st_q.work_reg),
    .result (or_mem_res)
  );

  always_comb begin
    shift_res = {mem_rdata[`ORE_KEEP_TOP:`ORE_LSB_BIT],
                 mem_rdata[`ORE_MSB_BIT]};
  end

  ore_zero_det #(
    .WIDTH   (`ORE_BYTE_W)
  ) u_imm_zero (
    .value   (or_imm_res),
    .is_zero (or_imm_zero)
  );

  ore_zero_det #(
    .WIDTH   (`ORE_BYTE_W)
  ) u_mem_zero (
    .value   (or_mem_res),
    .is_zero (or_mem_zero)
  );

  // Write data stays unregistered: memory takes the byte in the cycle of
  // the instruction itself, so a flop here would cost a whole cycle.
  always_comb begin
    mem_we    = 1'h0;
    mem_wdata = `ORE_ZERO_BYTE;
    if (is_or_mem) begin
      mem_we    = 1'h1;
      mem_wdata = or_mem_res;
    end else if (is_shift_up) begin
      mem_we    = 1'h1;
      mem_wdata = shift_res;
    end
  end

  assign stack_pop = is_any_exit;
  assign pc_load   = is_any_exit;

  always_comb begin
    st_d          = st_q;
    st_d.irq_take = `ORE_TAKE_RST;
    if (is_or_imm) begin
      st_d.work_reg  = or_imm_res;
      st_d.zero_flag = or_imm_zero;
    end
    if (is_or_mem) begin
      st_d.zero_flag = or_mem_zero;
    end
    if (is_sub_exit) begin
      st_d.pc = stack_top;
    end
    if (is_sub_exit_lit) begin
      st_d.pc       = stack_top;
      st_d.work_reg = op_literal;
    end
    if (is_irq_exit) begin
      st_d.irq_control_reg[`ORE_GIE_BIT] = 1'h1;
      // The vector wins over the popped address so the pending routine
      // runs first; the popped address is lost to the caller here, so
      // the controller must push it again on irq_enter.
      if (irq_divert) begin
        st_d.pc       = `ORE_IRQ_VECTOR;
        st_d.irq_take = 1'h1;
      end else begin
        st_d.pc = stack_top;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q.work_reg        <= `ORE_WORK_RST;
      st_q.zero_flag       <= `ORE_ZERO_RST;
      st_q.irq_control_reg <= `ORE_IRQ_CTRL_RST;
      st_q.pc              <= `ORE_PC_RST;
      st_q.irq_take        <= `ORE_TAKE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign pc_out            = st_q.pc;
  assign irq_enter         = st_q.irq_take;
  assign work_reg          = st_q.work_reg;
  assign zero_flag         = st_q.zero_flag;
  assign irq_control_reg   = st_q.irq_control_reg;
  assign global_irq_enable = st_q.irq_control_reg[`ORE_GIE_BIT];
endmodule

module ore_or_unit #(
  parameter int WIDTH = `ORE_BYTE_W
) (
  // Operands.
  input  wire logic [WIDTH-1:0] lhs,
  input  wire logic [WIDTH-1:0] rhs,
  // Bitwise OR of both operands.
  output logic      [WIDTH-1:0] result
);
  always_comb begin
    result = lhs | rhs;
  end
endmodule

module ore_zero_det #(
  parameter int WIDTH = `ORE_BYTE_W
) (
  // Value under test.
  input  wire logic [WIDTH-1:0] value,
  // High while every bit of the value is clear.
  output logic                  is_zero
);
  always_comb begin
    is_zero = (value == {WIDTH{1'h0}});
  end
endmodule

// File: rtl/ore_map.svh
`ifndef ORE_MAP_SVH
`define ORE_MAP_SVH
`define ORE_GIE_BIT        0
`define ORE_BYTE_W         8
`define ORE_PC_W           11
`define ORE_ZERO_BYTE      8'h00
`define ORE_IRQ_CTRL_RST   8'h00
`define ORE_ZERO_RST       1'h0
`define ORE_WORK_RST       8'h00
`define ORE_TAKE_RST       1'h0
`define ORE_LSB_BIT        0
`define ORE_KEEP_TOP       6
`define ORE_MSB_BIT        7
`define ORE_PC_RST         11'h000
`define ORE_IRQ_VECTOR     11'h004
`endif

// File: rtl/ore_pkg.sv
package ore_pkg;
  typedef enum logic [2:0] {
    ORE_OP_NONE,
    ORE_OP_OR_IMM,
    ORE_OP_OR_INTO_MEMORY,
    ORE_OP_SUBROUTINE_EXIT,
    ORE_OP_SUBROUTINE_EXIT_WITH_LITERAL,
    ORE_OP_IRQ_EXIT,
    ORE_OP_SHIFT_CIRCULAR_UP
  } ore_op_e;

  typedef struct packed {
    logic [7:0]  work_reg;
    logic        zero_flag;
    logic [7:0]  irq_control_reg;
    logic [10:0] pc;
    logic        irq_take;
  } ore_state_s;
endpackage

// File: tb/ore_exec_monitor.sv
`timescale 1ns/10ps
module ore_mon (
  // Clock and reset.
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // Instruction and operands.
  input wire logic             op_valid,
  input wire ore_pkg::ore_op_e op_code,
  input wire logic [7:0]       op_literal,
  input wire logic [7:0]       mem_rdata,
  input wire logic [10:0]      stack_top,
  input wire logic             irq_pending,
  // Block outputs.
  input wire logic             mem_we,
  input wire logic [7:0]       mem_wdata,
  input wire logic             stack_pop,
  input wire logic             pc_load,
  input wire logic [10:0]      pc_out,
  input wire logic             irq_enter,
  input wire logic [7:0]       work_reg,
  input wire logic             zero_flag,
  input wire logic [7:0]       irq_control_reg,
  input wire logic             global_irq_enable
);
  wire [2:0] k = op_valid ? op_code : 3'h0;
  wire [7:0] w = work_reg, d = mem_rdata;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  or_imm_a: assert property (k==1 |=> zero_flag==(w==0) &&
    w==($past(w)|$past(op_literal))) else $error("or imm");
  or_mem_a: assert property (k==2 |-> mem_we && mem_wdata==(d|w)
    ##1 zero_flag==($past(mem_wdata)==0) && $stable(w)) else $error("orm");
  ret_pc_a: assert property (k==3 |-> stack_pop ##1
    pc_out==$past(stack_top) && $stable(zero_flag)) else $error("ret");
  ret_lit_a: assert property (k==4 |=> w==$past(op_literal) &&
    $stable(zero_flag)) else $error("ret lit");
  irq_gie_a: assert property (k==5 |=> global_irq_enable &&
    $stable(zero_flag)) else $error("gie");
  irq_take_a: assert property (k==5 && irq_pending |=> irq_enter &&
    pc_out==11'h004) else $error("take");
  irq_back_a: assert property (k==5 && !irq_pending |=> !irq_enter &&
    pc_out==$past(stack_top)) else $error("back");
  rotate_up_a: assert property (k==6 |-> mem_we &&
    mem_wdata=={d[6:0],d[7]} ##1 $stable(zero_flag)) else $error("rot");
  exit_strobe_a: assert property (k inside {3,4,5} |->
    stack_pop && pc_load) else $error("exit strobe");
  exit_quiet_a: assert property (!(k inside {3,4,5}) |->
    !stack_pop && !pc_load) else $error("exit quiet");
  write_quiet_a: assert property (!(k inside {2,6}) |->
    !mem_we) else $error("write quiet");
  gie_mirror_a: assert property (global_irq_enable ==
    irq_control_reg[0]) else $error("gie mirror");
  cover property (k==5 && irq_pending);
  cover property (k==5 && !irq_pending);
  cover property (k==2 ##1 k==6);
  cover property (k==1 ##1 zero_flag);
endmodule
bind ore_exec ore_mon u_mon (
  .clk_sys           (clk_sys),
  .rst_n             (rst_n),
  .op_valid          (op_valid),
  .op_code           (op_code),
  .op_literal        (op_literal),
  .mem_rdata         (mem_rdata),
  .stack_top         (stack_top),
  .irq_pending       (irq_pending),
  .mem_we            (mem_we),
  .mem_wdata         (mem_wdata),
  .stack_pop         (stack_pop),
  .pc_load           (pc_load),
  .pc_out            (pc_out),
  .irq_enter         (irq_enter),
  .work_reg          (work_reg),
  .zero_flag         (zero_flag),
  .irq_control_reg   (irq_control_reg),
  .global_irq_enable (global_irq_enable)
);

// File: tb/test_ore_exec.sv
`timescale 1ns/10ps
module test_ore_exec;
  logic clk_sys = 0, rst_n = 0, op_valid = 0, irq_pending = 0, g = 0;
  logic mem_we, stack_pop, pc_load, irq_enter, zero_flag, global_irq_enable;
  logic [7:0] op_literal = 0, mem_rdata = 0, mem_wdata, work_reg, w = 0;
  logic [7:0] irq_control_reg;
  logic z = 0, t = 0;
  logic [10:0] stack_top = 0, pc_out, p = 0;
  ore_pkg::ore_op_e op_code = ore_pkg::ORE_OP_NONE;
  int seed = 33895, num_errors = 0, n_tests = 0, m;
  ore_exec dut (
    .clk_sys           (clk_sys),
    .rst_n             (rst_n),
    .op_valid          (op_valid),
    .op_code           (op_code),
    .op_literal        (op_literal),
    .mem_rdata         (mem_rdata),
    .stack_top         (stack_top),
    .irq_pending       (irq_pending),
    .mem_we            (mem_we),
    .mem_wdata         (mem_wdata),
    .stack_pop         (stack_pop),
    .pc_load           (pc_load),
    .pc_out            (pc_out),
    .irq_enter         (irq_enter),
    .work_reg          (work_reg),
    .zero_flag         (zero_flag),
    .irq_control_reg   (irq_control_reg),
    .global_irq_enable (global_irq_enable)
  );
  function automatic logic [7:0] exp_work(int op, logic [7:0] acc, lit);
    if (op == 1) return acc | lit;
    if (op == 4) return lit;
    return acc;
  endfunction
  function automatic logic exp_zero(int op, logic [7:0] acc, lit, dat,
                                    logic old);
    if (op == 1) return (acc | lit) == 0;
    if (op == 2) return (dat | acc) == 0;
    return old;
  endfunction
  always #2 clk_sys = ~clk_sys;
  initial #5000 tally_and_finish(1);
  task automatic chk(logic [10:0] s, e, string n);
    n_tests++;
    num_errors += s !== e;
    if (s !== e) $display("unexpected %s exp %h seen %h", n, e, s);
  endtask
  task automatic tally_and_finish(int late);
    num_errors += late;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    #1 rst_n = 1;
    for (int i = 0; i < 600; i++) begin
      {op_literal, mem_rdata, stack_top, irq_pending} = $random(seed);
      op_valid = i < 7 || $random(seed) & 1;
      op_code = ore_pkg::ore_op_e'(i < 7 ? i : $unsigned($random(seed)) % 7);
      // Zero literal on a clear work register must raise the zero flag.
      if (i < 7) {op_literal, irq_pending} = 9'h001;
      m = op_valid ? op_code : 0;
      z = exp_zero(m, w, op_literal, mem_rdata, z);
      w = exp_work(m, w, op_literal);
      if (m >= 3 && m <= 5) p = (m == 5 && irq_pending) ? 11'h004 : stack_top;
      t = m == 5 && irq_pending;
      g |= m == 5;
      @(posedge clk_sys) #1;
      chk(work_reg, w, "work_reg");
      chk(zero_flag, z, "zero_flag");
      chk(pc_out, p, "pc_out");
      chk(irq_enter, t, "irq_enter");
      chk(global_irq_enable, g, "global_irq_enable");
      chk(irq_control_reg, g, "irq_control_reg");
    end
    $display("random op run done");
    tally_and_finish(0);
  end
endmodule
